// ---- pvt_pkg.sv ----
// shared constants, types and helpers for the panel link
`default_nettype none
package pvt_pkg;
  // system clock
  localparam int CLK_KHZ = 40000;
  // pixel, lane, byte and counter widths
  localparam int PIX_W = 30;
  localparam int HALF_W = 15;
  localparam int BYTE_W = 8;
  localparam int CW = 12;
  localparam int TW = 25;
  localparam int UW = 8;
  // raster, counted in pixel beats and lines
  localparam int H_ACTIVE = 3840;
  localparam int H_BLANK_MIN = 140;
  localparam int H_BLANK_NOM = 160;
  localparam int H_BLANK_MAX = 180;
  localparam int LINE_TOTAL_CLOCKS_MIN = 3980;
  localparam int LINE_TOTAL_CLOCKS_NOM = 4000;
  localparam int LINE_TOTAL_CLOCKS_MAX = 4020;
  localparam int V_ACTIVE = 2160;
  localparam int V_BLANK = 62;
  localparam int VERTICAL_TOTAL_LINES = 2222;
  // real-time figures of the physical link
  localparam int FRAME_RATE_MIN_MHZ = 59700;
  localparam int FRAME_RATE_NOM_MHZ = 60000;
  localparam int FRAME_RATE_MAX_MHZ = 60300;
  localparam int PIXEL_CLOCK_FREQUENCY_KHZ = 533250;
  localparam int MAIN_LANE_BIT_TIME_PS = 185;
  localparam int SKEW_MAX = 20;
  // hot-plug and aux times in ns
  localparam int IRQ_MIN_NS = 500000;
  localparam int IRQ_MAX_NS = 1000000;
  localparam int UNPLUG_NS = 2000000;
  localparam int AUX_UI_MIN_NS = 400;
  localparam int AUX_UI_MAX_NS = 600;
  // power sequence times in ns
  localparam int T1_MIN_NS = 500000;
  localparam int T2_MIN_NS = 10000000;
  localparam int T3_MIN_NS = 15000000;
  localparam int T8_MIN_NS = 200000000;
  localparam int T12_MIN_NS = 500000000;
  // aux register addresses
  localparam logic [BYTE_W-1:0] CAPS_ADDR = 8'h01;
  localparam logic [BYTE_W-1:0] STAT_ADDR = 8'h02;

  // least time, rounded up, never below one cycle
  function automatic int cyc_min(input int ns);
    longint c;
    c = (longint'(ns) * CLK_KHZ + 999999) / 1000000;
    return (c < 1) ? 1 : int'(c);
  endfunction : cyc_min

  // longest time, rounded down, never below one cycle
  function automatic int cyc_max(input int ns);
    longint c;
    c = (longint'(ns) * CLK_KHZ) / 1000000;
    return (c < 1) ? 1 : int'(c);
  endfunction : cyc_max

  // value of a three-stage input once stages two and three agree
  function automatic logic agreed(input logic [2:0] s, input logic old);
    return (s[1] == s[2]) ? s[2] : old;
  endfunction : agreed

  localparam int IRQ_MIN_CYC = cyc_min(IRQ_MIN_NS);
  localparam int IRQ_PULSE_CYC = cyc_min((IRQ_MIN_NS + IRQ_MAX_NS) / 2);
  localparam int UNPLUG_CYC = cyc_min(UNPLUG_NS);
  localparam int AUX_UI_CYC = cyc_min((AUX_UI_MIN_NS + AUX_UI_MAX_NS) / 2);
  localparam int T1_CYC = cyc_min(T1_MIN_NS);
  localparam int T2_CYC = cyc_min(T2_MIN_NS);
  localparam int T3_CYC = cyc_min(T3_MIN_NS);
  localparam int T8_CYC = cyc_min(T8_MIN_NS);
  localparam int T12_CYC = cyc_min(T12_MIN_NS);

  typedef enum logic [3:0] {
    S_OFF = 4'h1,
    S_RISE = 4'h2,
    S_HPDW = 4'h4,
    S_LIVE = 4'h8
  } pvt_pwr_t;

  typedef enum logic [2:0] {
    A_IDLE = 3'h1,
    A_TX = 3'h2,
    A_RX = 3'h4
  } pvt_aux_t;
endpackage : pvt_pkg
`default_nettype wire

// ---- pvt_link_if.sv ----
// wires between the video source end and the panel end
`default_nettype none
interface pvt_link_if;
  logic vcc_en;
  logic hpd;
  logic aux_s2k;
  logic aux_k2s;
  logic valid;
  logic ready;
  logic [pvt_pkg::HALF_W-1:0] lane0;
  logic [pvt_pkg::HALF_W-1:0] lane1;
  logic act;
  logic sol;
  logic sof;
  modport src (output vcc_en, aux_s2k, valid, lane0, lane1, act, sol, sof,
               input hpd, aux_k2s, ready);
  modport snk (input vcc_en, aux_s2k, valid, lane0, lane1, act, sol, sof,
               output hpd, aux_k2s, ready);
endinterface : pvt_link_if
`default_nettype wire

// ---- pvt_fifo.sv ----
// first-in first-out buffer with valid and ready on both sides
`default_nettype none
module pvt_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  import pvt_pkg::*;
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } pvt_fifo_st_t;

  pvt_fifo_st_t st_reg;
  pvt_fifo_st_t st_next;
  logic full;
  logic empty;

  ////////////////////////////////////////////////////////////////////////////
  // flags from pointers, depth a power of two
  assign empty = st_reg.wp == st_reg.rp;
  assign full = (st_reg.wp[AW] != st_reg.rp[AW])
              && (st_reg.wp[AW-1:0] == st_reg.rp[AW-1:0]);
  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = st_reg.mem[st_reg.rp[AW-1:0]];

  // write and read
  always_comb
  begin
    st_next = st_reg;
    if (i_in_valid && !full)
    begin
      st_next.mem[st_reg.wp[AW-1:0]] = i_in_data;
      st_next.wp = st_reg.wp + 1'b1;
    end
    if (i_out_ready && !empty)
      st_next.rp = st_reg.rp + 1'b1;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end
endmodule : pvt_fifo
`default_nettype wire

// ---- pvt_sink.sv ----
// panel end: power-up, hot-plug line, aux answers, deskew and buffer
`default_nettype none
module pvt_sink #(
  parameter int DESKEW = 0,
  parameter int FIFO_DEPTH = 16,
  parameter logic [pvt_pkg::BYTE_W-1:0] CAPS = 8'h3c, // arbitrary value
  parameter int T2 = pvt_pkg::T2_CYC,
  parameter int T3 = pvt_pkg::T3_CYC,
  parameter int IRQ_PULSE = pvt_pkg::IRQ_PULSE_CYC
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_irq_req,
  input wire logic [pvt_pkg::BYTE_W-1:0] i_link_status,
  output logic o_pix_valid,
  output logic [pvt_pkg::PIX_W-1:0] o_pix_data,
  output logic o_pix_sol,
  output logic o_pix_sof,
  input wire logic i_pix_ready,
  output logic o_panel_on,
  output logic o_irq_busy,
  pvt_link_if.snk lnk
);
  import pvt_pkg::*;
  localparam int DK = (DESKEW > SKEW_MAX) ? SKEW_MAX : DESKEW;
  localparam int DKI = (DK == 0) ? 0 : DK - 1;
  localparam int EW = HALF_W + 3;

  typedef struct packed {
    pvt_pwr_t pwr;
    logic [TW-1:0] tmr;
    logic [2:0] vsy;
    logic vcc;
    logic [2:0] asy;
    logic arx;
    logic [TW-1:0] irq;
    logic [SKEW_MAX-1:0][EW-1:0] dly;
    pvt_aux_t aux;
    logic [UW-1:0] ui;
    logic [3:0] nb;
    logic [BYTE_W+1:0] sh;
  } pvt_snk_st_t;

  localparam pvt_snk_st_t RST = '{pwr: S_OFF, aux: A_IDLE, sh: '1,
                                  default: '0};
  pvt_snk_st_t st_reg;
  pvt_snk_st_t st_next;
  logic [EW-1:0] tap;
  logic fifo_ready;
  logic [PIX_W+1:0] fifo_out;

  ////////////////////////////////////////////////////////////////////////////
  // lane 0 and flags taken late by the deskew depth
  assign tap = (DK == 0) ? {lnk.sof, lnk.sol, lnk.act, lnk.lane0}
                         : st_reg.dly[DKI];
  assign lnk.ready = fifo_ready;
  assign lnk.hpd = st_reg.pwr == S_LIVE && st_reg.irq == '0;
  assign lnk.aux_k2s = st_reg.vcc && (st_reg.aux != A_TX || st_reg.sh[0]);
  assign o_panel_on = st_reg.pwr == S_LIVE;
  assign o_irq_busy = st_reg.irq != '0;
  assign o_pix_data = fifo_out[PIX_W-1:0];
  assign o_pix_sol = fifo_out[PIX_W];
  assign o_pix_sof = fifo_out[PIX_W+1];

  // active pixels queue up toward the panel
  pvt_fifo #(.W(PIX_W + 2), .D(FIFO_DEPTH)) u_fifo (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_in_valid(lnk.valid && tap[HALF_W]),
    .o_in_ready(fifo_ready),
    .i_in_data({tap[HALF_W+2], tap[HALF_W+1], lnk.lane1, tap[HALF_W-1:0]}),
    .o_out_valid(o_pix_valid),
    .i_out_ready(i_pix_ready),
    .o_out_data(fifo_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // power, hot-plug, aux and deskew state
  always_comb
  begin
    st_next = st_reg;
    st_next.vsy = {st_reg.vsy[1:0], lnk.vcc_en};
    st_next.vcc = agreed(st_reg.vsy, st_reg.vcc);
    st_next.asy = {st_reg.asy[1:0], lnk.aux_s2k};
    st_next.arx = agreed(st_reg.asy, st_reg.arx);
    if (st_reg.tmr != '0)
      st_next.tmr = st_reg.tmr - 1'b1;
    if (st_reg.irq != '0)
      st_next.irq = st_reg.irq - 1'b1;
    // supply up, hot-plug raised after the settling time
    case (st_reg.pwr)
      S_OFF:
        if (st_reg.vcc)
        begin
          st_next.pwr = S_RISE;
          st_next.tmr = TW'(T3);
        end
      S_RISE:
        if (!st_reg.vcc)
          st_next.pwr = S_OFF;
        else if (st_reg.tmr == '0)
          st_next.pwr = S_LIVE;
      S_LIVE:
        if (!st_reg.vcc)
        begin
          st_next.pwr = S_OFF;
          st_next.irq = '0;
        end
        else if (i_irq_req && st_reg.irq == '0)
          st_next.irq = TW'(IRQ_PULSE);
      default:
        st_next.pwr = S_OFF;
    endcase
    // deskew line shifts on each accepted beat
    if (lnk.valid && fifo_ready)
      st_next.dly = {st_reg.dly[SKEW_MAX-2:0],
                     {lnk.sof, lnk.sol, lnk.act, lnk.lane0}};
    // aux: receive an address byte, answer with one data byte
    case (st_reg.aux)
      A_IDLE:
        if (!st_reg.arx && st_reg.vcc && (st_reg.pwr == S_LIVE
            || (st_reg.pwr == S_RISE && st_reg.tmr <= TW'(T3 - T2))))
        begin
          st_next.aux = A_RX;
          st_next.ui = UW'(AUX_UI_CYC + AUX_UI_CYC / 2);
          st_next.nb = 4'(BYTE_W);
        end
      A_RX:
        if (st_reg.ui == UW'(1))
        begin
          st_next.sh = {st_reg.arx, st_reg.sh[BYTE_W+1:1]};
          st_next.ui = UW'(AUX_UI_CYC);
          st_next.nb = st_reg.nb - 1'b1;
          if (st_reg.nb == 4'h1)
          begin
            st_next.aux = A_TX;
            st_next.nb = 4'(BYTE_W + 2);
            if (st_next.sh[BYTE_W+1:2] == CAPS_ADDR)
              st_next.sh = {CAPS, 2'h1};
            else if (st_next.sh[BYTE_W+1:2] == STAT_ADDR)
              st_next.sh = {i_link_status, 2'h1};
            else
              st_next.sh = {{BYTE_W{1'b0}}, 2'h1};
          end
        end
        else
          st_next.ui = st_reg.ui - 1'b1;
      A_TX:
        if (st_reg.ui == UW'(1))
        begin
          st_next.sh = {1'b1, st_reg.sh[BYTE_W+1:1]};
          st_next.ui = UW'(AUX_UI_CYC);
          st_next.nb = st_reg.nb - 1'b1;
          if (st_reg.nb == 4'h1)
            st_next.aux = A_IDLE;
        end
        else
          st_next.ui = st_reg.ui - 1'b1;
      default:
        st_next.aux = A_IDLE;
    endcase
    if (!st_reg.vcc)
      st_next.aux = A_IDLE;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      st_reg <= RST;
    else
      st_reg <= st_next;
  end
endmodule : pvt_sink
`default_nettype wire

// ---- pvt_source.sv ----
// video source end: power order, raster, hot-plug watch and aux reads
`default_nettype none
// Behaviour
// - exactly 2160 active lines per frame
// - then 62 blanking lines, 2222 total
// - exactly 3840 active pixels per line
// - line blanking 140 to 180, nominal 160
// - line total 3980 to 4020, nominal 4000
// - frame rate 59.7 to 60.3 Hz
// - rate times raster within pixel clock range
// - hot-plug pulse 0.5-1 ms means interrupt
// - hot-plug low 2 ms means unplug
// - interrupt: read link and receiver status
// - plug: read capabilities, then status
// - aux bit period 0.4 to 0.6 us
// - lane skew within 20 bit times
// - source power intervals kept
// - panel power intervals kept
// - supply off: inputs low, never high
// - supply on: interface actively driven
// - backlight on after panel, off before (switched off here in the same cycle as the panel supply)
module pvt_source #(
  parameter int H_BLANK = pvt_pkg::H_BLANK_NOM,
  parameter int LANE_SKEW = 0,
  parameter int T1 = pvt_pkg::T1_CYC,
  parameter int T8 = pvt_pkg::T8_CYC,
  parameter int T12 = pvt_pkg::T12_CYC,
  parameter int IRQ_MIN = pvt_pkg::IRQ_MIN_CYC,
  parameter int UNPLUG = pvt_pkg::UNPLUG_CYC
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_power_on,
  input wire logic [pvt_pkg::PIX_W-1:0] i_pix_data,
  output logic o_pix_take,
  output logic o_backlight_en,
  output logic o_link_up,
  output logic o_plug,
  output logic o_unplug,
  output logic o_irq_seen,
  output logic o_aux_done,
  output logic [pvt_pkg::BYTE_W-1:0] o_aux_addr,
  output logic [pvt_pkg::BYTE_W-1:0] o_aux_data,
  pvt_link_if.src lnk
);
  import pvt_pkg::*;
  // blanking held inside its legal window
  localparam int HB = (H_BLANK < H_BLANK_MIN) ? H_BLANK_MIN
                    : (H_BLANK > H_BLANK_MAX) ? H_BLANK_MAX : H_BLANK;
  localparam int HT = H_ACTIVE + HB;
  localparam int SK = (LANE_SKEW > SKEW_MAX) ? SKEW_MAX : LANE_SKEW;
  localparam int SKI = (SK == 0) ? 0 : SK - 1;

  typedef struct packed {
    pvt_pwr_t pwr;
    logic [TW-1:0] tmr;
    logic bl;
    logic [2:0] hsy;
    logic hpd;
    logic [TW-1:0] low;
    logic [2:0] asy;
    logic arx;
    logic [CW-1:0] hc;
    logic [CW-1:0] vc;
    logic [SKEW_MAX-1:0][HALF_W-1:0] dly;
    logic bv;
    logic [HALF_W-1:0] l0;
    logic [HALF_W-1:0] l1;
    logic act;
    logic sol;
    logic sof;
    pvt_aux_t aux;
    logic [UW-1:0] ui;
    logic [3:0] nb;
    logic [BYTE_W:0] sh;
    logic need_cap;
    logic need_st;
    logic [BYTE_W-1:0] addr;
    logic [BYTE_W-1:0] dat;
    logic done;
    logic plug;
    logic unplug;
    logic irq;
    logic take;
  } pvt_src_st_t;

  localparam pvt_src_st_t RST = '{pwr: S_OFF, aux: A_IDLE, default: '0};
  pvt_src_st_t st_reg;
  pvt_src_st_t st_next;
  logic [HALF_W-1:0] half0;
  logic [HALF_W-1:0] half1;
  logic in_act;

  ////////////////////////////////////////////////////////////////////////////
  // pins: everything low while the supply is off
  assign lnk.vcc_en = st_reg.pwr != S_OFF;
  assign lnk.valid = st_reg.bv;
  assign lnk.lane0 = st_reg.l0;
  assign lnk.lane1 = st_reg.l1;
  assign lnk.act = st_reg.act;
  assign lnk.sol = st_reg.sol;
  assign lnk.sof = st_reg.sof;
  assign lnk.aux_s2k = lnk.vcc_en
                    && (st_reg.aux != A_TX || st_reg.sh[0]);
  assign o_backlight_en = st_reg.bl;
  assign o_link_up = st_reg.pwr == S_LIVE;
  assign o_plug = st_reg.plug;
  assign o_unplug = st_reg.unplug;
  assign o_irq_seen = st_reg.irq;
  assign o_aux_done = st_reg.done;
  assign o_aux_addr = st_reg.addr;
  assign o_aux_data = st_reg.dat;
  assign o_pix_take = st_next.take;

  // raster position decides active or blank
  assign in_act = st_reg.hc < CW'(H_ACTIVE)
               && st_reg.vc < CW'(V_ACTIVE);
  assign half0 = in_act ? i_pix_data[HALF_W-1:0] : '0;
  assign half1 = in_act ? i_pix_data[PIX_W-1:HALF_W] : '0;

  ////////////////////////////////////////////////////////////////////////////
  // whole next state
  always_comb
  begin
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.plug = 1'b0;
    st_next.unplug = 1'b0;
    st_next.irq = 1'b0;
    st_next.take = 1'b0;
    st_next.hsy = {st_reg.hsy[1:0], lnk.hpd};
    st_next.hpd = agreed(st_reg.hsy, st_reg.hpd);
    st_next.asy = {st_reg.asy[1:0], lnk.aux_k2s};
    st_next.arx = agreed(st_reg.asy, st_reg.arx);
    if (st_reg.tmr != '0)
      st_next.tmr = st_reg.tmr - 1'b1;

    // hot-plug low time: short pulse is interrupt, long is unplug
    if (st_reg.hpd)
    begin
      if (st_reg.pwr == S_LIVE && st_reg.low >= TW'(IRQ_MIN)
          && st_reg.low < TW'(UNPLUG))
      begin
        st_next.irq = 1'b1;
        st_next.need_st = 1'b1;
      end
      st_next.low = '0;
    end
    else if (st_reg.low != TW'(UNPLUG))
    begin
      st_next.low = st_reg.low + 1'b1;
      if (st_reg.low == TW'(UNPLUG - 1) && st_reg.pwr == S_LIVE)
        st_next.unplug = 1'b1;
    end

    // power order and backlight
    case (st_reg.pwr)
      S_OFF:
        if (i_power_on && st_reg.tmr == '0)
        begin
          st_next.pwr = S_RISE;
          st_next.tmr = TW'(T1);
        end
      S_RISE, S_HPDW:
        if (!i_power_on)
        begin
          st_next.pwr = S_OFF;
          st_next.tmr = TW'(T12);
        end
        else if (st_reg.pwr == S_RISE)
        begin
          if (st_reg.tmr == '0)
            st_next.pwr = S_HPDW;
        end
        else if (st_reg.hpd)
        begin
          st_next.pwr = S_LIVE;
          st_next.tmr = TW'(T8);
          st_next.plug = 1'b1;
          st_next.need_cap = 1'b1;
          st_next.need_st = 1'b1;
        end
      S_LIVE:
        if (!i_power_on)
        begin
          st_next.bl = 1'b0;
          st_next.pwr = S_OFF;
          st_next.tmr = TW'(T12);
        end
        else if (st_next.unplug)
        begin
          st_next.bl = 1'b0;
          st_next.pwr = S_HPDW;
        end
        else if (st_reg.tmr == '0)
          st_next.bl = 1'b1;
      default:
        st_next.pwr = S_OFF;
    endcase

    // raster beats, held until the panel takes them
    if (st_next.pwr == S_LIVE)
    begin
      if (!st_reg.bv || lnk.ready)
      begin
        st_next.bv = 1'b1;
        st_next.act = in_act;
        st_next.take = in_act;
        st_next.sol = st_reg.hc == '0;
        st_next.sof = st_reg.hc == '0 && st_reg.vc == '0;
        st_next.l0 = half0;
        st_next.dly = {st_reg.dly[SKEW_MAX-2:0], half1};
        st_next.l1 = (SK == 0) ? half1 : st_reg.dly[SKI];
        // line of 3840 active then blanking, frame of 2160 then 62
        if (st_reg.hc == CW'(HT - 1))
        begin
          st_next.hc = '0;
          if (st_reg.vc == CW'(VERTICAL_TOTAL_LINES - 1))
            st_next.vc = '0;
          else
            st_next.vc = st_reg.vc + 1'b1;
        end
        else
          st_next.hc = st_reg.hc + 1'b1;
      end
    end
    else
    begin
      // main link parked low, raster restarts at frame top
      st_next.bv = 1'b0;
      st_next.act = 1'b0;
      st_next.sol = 1'b0;
      st_next.sof = 1'b0;
      st_next.l0 = '0;
      st_next.l1 = '0;
      st_next.hc = '0;
      st_next.vc = '0;
    end

    // aux reads: send address byte, then receive one data byte
    case (st_reg.aux)
      A_IDLE:
        if (st_reg.pwr == S_LIVE && (st_reg.need_cap || st_reg.need_st))
        begin
          st_next.addr = st_reg.need_cap ? CAPS_ADDR : STAT_ADDR;
          if (st_reg.need_cap)
            st_next.need_cap = 1'b0;
          else
            st_next.need_st = 1'b0;
          st_next.sh = {st_next.addr, 1'b0};
          st_next.nb = 4'(BYTE_W + 1);
          st_next.ui = UW'(AUX_UI_CYC);
          st_next.aux = A_TX;
        end
      A_TX:
        if (st_reg.ui == UW'(1))
        begin
          st_next.sh = {1'b1, st_reg.sh[BYTE_W:1]};
          st_next.ui = UW'(AUX_UI_CYC);
          st_next.nb = st_reg.nb - 1'b1;
          if (st_reg.nb == 4'h1)
          begin
            st_next.aux = A_RX;
            st_next.nb = '0;
          end
        end
        else
          st_next.ui = st_reg.ui - 1'b1;
      A_RX:
        if (st_reg.nb == '0)
        begin
          if (!st_reg.arx)
          begin
            st_next.ui = UW'(AUX_UI_CYC + AUX_UI_CYC / 2);
            st_next.nb = 4'(BYTE_W);
          end
        end
        else if (st_reg.ui == UW'(1))
        begin
          st_next.sh = {st_reg.arx, st_reg.sh[BYTE_W:1]};
          st_next.ui = UW'(AUX_UI_CYC);
          st_next.nb = st_reg.nb - 1'b1;
          if (st_reg.nb == 4'h1)
          begin
            st_next.dat = st_next.sh[BYTE_W:1];
            st_next.done = 1'b1;
            st_next.aux = A_IDLE;
          end
        end
        else
          st_next.ui = st_reg.ui - 1'b1;
      default:
        st_next.aux = A_IDLE;
    endcase
    if (st_next.pwr != S_LIVE)
    begin
      st_next.aux = A_IDLE;
      st_next.need_cap = 1'b0;
      st_next.need_st = 1'b0;
    end
  end

  // the line and frame counts above give 2222 x 4000 beats per frame;
  // at the real 533.25 MHz pixel rate that is a 60 Hz frame
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      st_reg <= RST;
    else
      st_reg <= st_next;
  end
endmodule : pvt_source
`default_nettype wire

// ---- pvt_link_props.sv ----
// assertions on the wires between the source end and the panel end
`default_nettype none
module pvt_link_props
  import pvt_pkg::*;
#(
  parameter int LINE_T = 4000,
  parameter int IRQ_W = 75,
  parameter int T3 = 30
)
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic vcc_en,
  input wire logic hpd,
  input wire logic aux_s2k,
  input wire logic valid,
  input wire logic ready,
  input wire logic [pvt_pkg::HALF_W-1:0] lane0,
  input wire logic [pvt_pkg::HALF_W-1:0] lane1,
  input wire logic act,
  input wire logic sol,
  input wire logic sof
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);
  logic acc;
  logic [12:0] hc_reg, ac_reg;
  logic [7:0] lc_reg, lr_reg, vc_reg;
  logic run_reg, blk_reg, seen_reg;
  assign acc = valid && ready;
  ////////////////////////////////////////////////////////////////////////
  // beat counts per line, low-time and supply-time counters
  always_ff @(posedge i_clock)
  begin
    if (acc)
    begin
      hc_reg <= sol ? 13'h1 : hc_reg + 13'h1;
      ac_reg <= sol ? 13'(act) : ac_reg + 13'(act);
      blk_reg <= sol ? !act : (blk_reg || !act);
    end
    lc_reg <= hpd ? 8'h0 : lc_reg + 8'h1;
    lr_reg <= (aux_s2k || !seen_reg) ? 8'h0 : lr_reg + 8'h1;
    vc_reg <= !vcc_en ? 8'h0 : vc_reg + 8'(vc_reg != 8'hff);
    seen_reg <= i_rstn && vcc_en && (seen_reg || hpd);
    run_reg <= i_rstn && vcc_en && (run_reg || (acc && sol));
  end
  ////////////////////////////////////////////////////////////////////////
  property p_off_quiet;
    !vcc_en |-> !valid && !aux_s2k && !act;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("link driven while supply off");
  property p_hold;
    valid && !ready |=> !vcc_en
      || (valid && $stable({lane0, lane1, act, sol, sof}));
  endproperty
  a_hold: assert property (p_hold)
    else $error("stalled beat changed");
  property p_line_len;
    acc && sol && run_reg |-> hc_reg == 13'(LINE_T);
  endproperty
  a_line_len: assert property (p_line_len)
    else $error("line length wrong");
  property p_act_cnt;
    acc && sol && run_reg |-> ac_reg == 13'(H_ACTIVE);
  endproperty
  a_act_cnt: assert property (p_act_cnt)
    else $error("active beats per line wrong");
  property p_act_first;
    acc && act && !sol |-> !blk_reg;
  endproperty
  a_act_first: assert property (p_act_first)
    else $error("active beat after blanking");
  property p_irq_width;
    $rose(hpd) && seen_reg |-> lc_reg == 8'(IRQ_W);
  endproperty
  a_irq_width: assert property (p_irq_width)
    else $error("hot-plug pulse width wrong");
  property p_plug_wait;
    $rose(hpd) && !seen_reg && vcc_en |->
      vc_reg >= 8'(T3) && vc_reg <= 8'(T3 + 10);
  endproperty
  a_plug_wait: assert property (p_plug_wait)
    else $error("hot-plug raised at wrong time after supply");
  property p_aux_bit;
    $rose(aux_s2k) && seen_reg && lr_reg != 8'h0 |->
      lr_reg % 8'(AUX_UI_CYC) == 8'h0;
  endproperty
  a_aux_bit: assert property (p_aux_bit)
    else $error("aux low run not whole bits");
  c_stall: cover property (valid && !ready);
  c_line: cover property (acc && sol && run_reg);
  c_irq: cover property ($rose(hpd) && seen_reg);
endmodule : pvt_link_props
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench joining the source end and the panel end
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pvt_pkg::*;
  localparam int T8 = 100;
  localparam int T12 = 100;
  localparam int HB = 140, SK = 20, IRQ_P = 75, T3 = 30;
  localparam logic [7:0] CAPS_V = 8'h5a; // arbitrary value
  logic i_clock, i_rstn, power_on, irq_req, pix_ready, stall, vid_on;
  logic take, bl_en, link_up, plug, unplug, irq_seen, aux_done;
  logic pv, psol, psof, irq_busy, panel_on;
  logic [7:0] aux_addr, aux_data, status;
  logic [PIX_W-1:0] pix_data, pd;
  logic [PIX_W-1:0] exp_q[$];
  int seed = 23;
  int err_count, checks, idx, cyc, irq_cnt, unp_cnt;
  pvt_link_if lnk();
  pvt_source #(.H_BLANK(HB), .LANE_SKEW(SK), .T1(10), .T8(T8),
    .T12(T12), .IRQ_MIN(50), .UNPLUG(200)) pvt_source_inst (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_power_on(power_on),
    .i_pix_data(pix_data), .o_pix_take(take), .o_backlight_en(bl_en),
    .o_link_up(link_up), .o_plug(plug), .o_unplug(unplug),
    .o_irq_seen(irq_seen), .o_aux_done(aux_done),
    .o_aux_addr(aux_addr), .o_aux_data(aux_data), .lnk(lnk.src));
  pvt_sink #(.DESKEW(SK), .CAPS(CAPS_V), .T2(20), .T3(T3),
    .IRQ_PULSE(IRQ_P)) pvt_sink_inst (.i_clock(i_clock), .i_rstn(i_rstn),
    .i_irq_req(irq_req), .i_link_status(status), .o_pix_valid(pv),
    .o_pix_data(pd), .o_pix_sol(psol), .o_pix_sof(psof),
    .i_pix_ready(pix_ready), .o_panel_on(panel_on), .o_irq_busy(irq_busy),
    .lnk(lnk.snk));
  pvt_link_props #(.LINE_T(H_ACTIVE + HB), .IRQ_W(IRQ_P), .T3(T3))
    pvt_link_props_inst (.i_clock(i_clock), .i_rstn(i_rstn),
    .vcc_en(lnk.vcc_en), .hpd(lnk.hpd), .aux_s2k(lnk.aux_s2k),
    .valid(lnk.valid), .ready(lnk.ready), .lane0(lnk.lane0),
    .lane1(lnk.lane1), .act(lnk.act), .sol(lnk.sol), .sof(lnk.sof));
  ////////////////////////////////////////////////////////////////////////
  // expected line and frame flags of the n-th pixel
  function automatic logic [1:0] exp_flags(input int n);
    return {n % H_ACTIVE == 0, n == 0};
  endfunction : exp_flags
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic step();
    @(posedge i_clock);
    #2;
  endtask : step
  // wait for an aux read and compare address and byte
  task automatic read_chk(input logic [7:0] a, input logic [7:0] d);
    for (int n = 0; n < 2000 && aux_done !== 1'b1; n++)
      step();
    check(32'({aux_done, aux_addr, aux_data}), 32'({1'b1, a, d}));
    step();
  endtask : read_chk
  task automatic plug_reads();
    for (int n = 0; n < 3000 && plug !== 1'b1; n++)
      step();
    check(32'({plug, link_up, panel_on}), 32'h7);
    read_chk(CAPS_ADDR, CAPS_V);
    read_chk(STAT_ADDR, status);
    $display("test plug reads done");
  endtask : plug_reads
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  // random pixels and panel-side ready
  always @(posedge i_clock)
  begin
    #2;
    pix_data <= PIX_W'($random(seed));
    pix_ready <= !stall && ($random(seed) % 4 != 0);
  end
  // pixel scoreboard, backlight order, event counts, timeout
  always @(posedge i_clock)
  begin
    if (take && vid_on)
      exp_q.push_back(pix_data);
    if (pv && pix_ready && vid_on)
    begin
      check(32'(pd), 32'(exp_q.pop_front()));
      check(32'({psol, psof}), 32'(exp_flags(idx)));
      idx++;
    end
    if ($rose(bl_en))
      check(32'($past(link_up, T8)), 32'h1);
    if (bl_en)
      check(32'(link_up), 32'h1);
    irq_cnt += int'(irq_seen);
    unp_cnt += int'(unplug);
    cyc++;
    if (cyc > 40000)
    begin
      err_count++;
      complete_run();
    end
  end
  // main sequence
  initial
  begin
    i_rstn = 1'b0;
    power_on = 1'b0;
    irq_req = 1'b0;
    stall = 1'b0;
    vid_on = 1'b1;
    pix_ready = 1'b0;
    pix_data = '0;
    status = 8'($random(seed));
    repeat (4) @(posedge i_clock);
    #2;
    i_rstn = 1'b1;
    power_on = 1'b1;
    plug_reads();
    // fill the panel buffer until it refuses
    stall = 1'b1;
    repeat (60) step();
    check(32'({lnk.ready, lnk.valid}), 32'h1);
    stall = 1'b0;
    for (int n = 0; n < 30000 && idx < 2 * H_ACTIVE + 8; n++)
      step();
    check(32'(idx >= 2 * H_ACTIVE + 8), 32'h1);
    $display("test video lines done");
    // interrupt, second request refused while the pulse runs
    status = 8'($random(seed));
    irq_req = 1'b1;
    step();
    irq_req = 1'b0;
    repeat (5) step();
    check(32'(irq_busy), 32'h1);
    irq_req = 1'b1;
    step();
    irq_req = 1'b0;
    read_chk(STAT_ADDR, status);
    check(32'(irq_cnt), 32'h1);
    check(32'(unp_cnt), 32'h0);
    $display("test interrupt done");
    // power down, early power-on refused, then re-plug
    vid_on = 1'b0;
    power_on = 1'b0;
    repeat (2) step();
    check(32'({bl_en, lnk.vcc_en, lnk.valid}), 32'h0);
    power_on = 1'b1;
    repeat (T12 / 2) step();
    check(32'(lnk.vcc_en), 32'h0);
    plug_reads();
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
